// ==== flash_model.sv ====
`timescale 1ns/100ps
module flash_model (
    input  wire        i_clk,  // core clock
    input  wire        i_rd,   // read strobe
    input  wire [20:0] i_addr, // byte address
    output reg  [15:0] o_rdata // word, cycle after strobe
);
    // content follows the address, distinct per word within each 64K block and never zero
    function automatic [15:0] word_of(input [20:0] a);
        word_of = {a[15:8] ^ {3'h0, a[20:16]}, a[7:1], 1'b1};
    endfunction
    // data valid one cycle only; toggling afterwards exposes late sampling
    always @(posedge i_clk) begin
        if (i_rd)
            o_rdata <= word_of(i_addr);
        else
            o_rdata <= ~o_rdata;
    end
    initial o_rdata = 16'h0000;
endmodule // flash_model

// ==== prog_mem_map.v ====
`timescale 1ns/100ps
`include "prog_mem_map_defines.vh"

module prog_mem_map #(
    parameter DATA_AW = 12                          // data memory address width
) (
    input  wire                 i_clk,              // core clock
    input  wire                 i_rst,              // synchronous reset, high
    input  wire [1:0]           i_size_sel,         // on-chip memory size option
    output wire [`PC_W-1:0]     o_flash_addr,       // flash byte address
    output wire                 o_flash_rd,         // flash read strobe
    input  wire [15:0]          i_flash_rdata,      // flash word, cycle after read
    input  wire                 i_fetch_req,        // core asks for next instruction
    output wire                 o_fetch_valid,      // instruction word valid
    output wire [15:0]          o_fetch_instr,      // fetched instruction word
    output wire [`PC_W-1:0]     o_fetch_pc,         // address of fetched word
    output wire [`PC_W-1:0]     o_pc,               // current program counter
    input  wire                 i_pc_load,          // core writes the pc
    input  wire [`PC_W-1:0]     i_pc_value,         // new pc value
    input  wire                 i_wake_irq,         // wake-up caused by interrupt
    input  wire                 i_wake_high,        // wake interrupt is high priority
    input  wire                 i_low_priority_global_irq_enable,  // low enable
    input  wire                 i_high_priority_global_irq_enable, // high enable
    input  wire                 i_sp_load,          // core writes stack pointer
    input  wire [`SP_W-1:0]     i_sp_value,         // new stack pointer value
    output wire [`SP_W-1:0]     o_return_stack_pointer, // stack pointer
    output wire                 o_stack_push,       // top-of-stack written
    output wire [4:0]           o_stack_top_upper_byte, // pushed pc 20:16
    output wire [7:0]           o_stack_top_high_byte,  // pushed pc 15:8
    output wire [7:0]           o_stack_top_low_byte,   // pushed pc 7:0
    input  wire                 i_dmem_en,          // data memory access
    input  wire                 i_dmem_we,          // data memory write
    input  wire [DATA_AW-1:0]   i_dmem_addr,        // data memory address
    input  wire [7:0]           i_dmem_wdata,       // data memory write byte
    output wire [7:0]           o_dmem_rdata,       // data memory read byte
    output wire                 o_dmem_valid,       // read byte valid
    output wire [15:0]          o_setup_word_one,   // configuration word one
    output wire [15:0]          o_setup_word_two,   // configuration word two
    output wire [15:0]          o_setup_word_three, // configuration word three
    output wire [15:0]          o_setup_word_reserved, // reserved fourth word
    output wire                 o_cfg_done          // configuration copied
);

    // sequencer states
    localparam [1:0] S_STRAP = 2'h0;
    localparam [1:0] S_CFG   = 2'h1;
    localparam [1:0] S_RUN   = 2'h2;

    // top-of-memory boundary for a size option; unknown codes fall back to 64K
    function [`PC_W-1:0] top_of_mem;
        input [1:0] sel;
        begin
            if (sel == `SIZE_128K) begin
                top_of_mem = `TOP_128K;
            end else if (sel == `SIZE_96K) begin
                top_of_mem = `TOP_96K;
            end else begin
                top_of_mem = `TOP_64K;
            end
        end
    endfunction

    reg  [1:0]           state_ff;
    reg  [1:0]           nxt_state;
    reg  [1:0]           size_ff;
    reg  [1:0]           nxt_size;
    reg  [2:0]           cfg_cnt_ff;
    reg  [2:0]           nxt_cfg_cnt;
    reg  [`PC_W-1:0]     pc_ff;
    reg  [`PC_W-1:0]     nxt_pc;
    reg  [`SP_W-1:0]     sp_ff;
    reg  [`SP_W-1:0]     nxt_sp;
    reg                  push_ff;
    reg                  nxt_push;
    reg  [`PC_W-1:0]     tos_ff;
    reg  [`PC_W-1:0]     nxt_tos;
    reg  [`PC_W-1:0]     faddr_ff;
    reg  [`PC_W-1:0]     nxt_faddr;
    reg                  frd_ff;
    reg                  nxt_frd;
    reg                  fkind_ff;
    reg                  nxt_fkind;
    reg  [1:0]           ftag_ff;
    reg  [1:0]           nxt_ftag;
    reg                  fzero_ff;
    reg                  nxt_fzero;
    // second pipeline stage, aligned with the returning flash word
    reg                  rd_d_ff;
    reg                  kind_d_ff;
    reg  [1:0]           tag_d_ff;
    reg                  zero_d_ff;
    reg  [`PC_W-1:0]     addr_d_ff;
    reg                  fvalid_ff;
    reg  [15:0]          finstr_ff;
    reg  [`PC_W-1:0]     fpc_ff;
    wire [63:0]          cfg_flat;
    reg                  done_ff;
    reg  [7:0]           dram [0:(1<<DATA_AW)-1];
    reg  [7:0]           drdata_ff;
    reg                  dvalid_ff;

    wire [`PC_W-1:0]     top_addr;
    wire [`PC_W-1:0]     cfg_base;
    wire                 wake_vector;
    wire [15:0]          word_in;

    assign top_addr    = top_of_mem(size_ff);
    assign cfg_base    = top_addr - `CFG_AREA_BYTES;
    // a wake without either global enable just resumes where it stopped
    assign wake_vector = i_wake_irq & (i_low_priority_global_irq_enable |
                                       i_high_priority_global_irq_enable);
    // beyond the implemented memory the flash answer is discarded
    assign word_in     = zero_d_ff ? `NOP_WORD : i_flash_rdata;

    // sequencer: strap capture, configuration copy, then instruction fetch
    always @* begin
        nxt_state   = state_ff;
        nxt_size    = size_ff;
        nxt_cfg_cnt = cfg_cnt_ff;
        nxt_pc      = pc_ff;
        nxt_sp      = sp_ff;
        nxt_push    = 1'b0;
        nxt_tos     = tos_ff;
        nxt_faddr   = faddr_ff;
        nxt_frd     = 1'b0;
        nxt_fkind   = 1'b0;
        nxt_ftag    = 2'h0;
        nxt_fzero   = 1'b0;
        case (state_ff)
            S_STRAP: begin
                // size is caught after release so reset loads only constants
                nxt_size    = i_size_sel;
                nxt_cfg_cnt = 3'h0;
                nxt_state   = S_CFG;
            end
            S_CFG: begin
                // one read per cycle, word one at the lowest address
                if (cfg_cnt_ff != `CFG_WORDS) begin
                    nxt_frd     = 1'b1;
                    nxt_fkind   = 1'b1;
                    nxt_ftag    = cfg_cnt_ff[1:0];
                    nxt_faddr   = cfg_base + {17'h0, cfg_cnt_ff, 1'b0};
                    nxt_cfg_cnt = cfg_cnt_ff + 3'h1;
                end
                // fetching waits for the last word to land
                if (kind_d_ff && rd_d_ff && tag_d_ff == `CFG_LAST_IDX) begin
                    nxt_state = S_RUN;
                end
            end
            S_RUN: begin
                if (wake_vector) begin
                    // wake outranks a fetch request in the same cycle
                    nxt_tos  = pc_ff;
                    nxt_push = 1'b1;
                    if (sp_ff != `SP_MAX) begin
                        nxt_sp = sp_ff + `SP_STEP;
                    end
                    nxt_pc = i_wake_high ? `VEC_HIGH : `VEC_LOW;
                end else if (i_pc_load) begin
                    // word alignment: the low pc bit is held at zero
                    nxt_pc = {i_pc_value[`PC_W-1:1], 1'b0};
                end else if (i_fetch_req) begin
                    nxt_frd   = 1'b1;
                    nxt_faddr = pc_ff;
                    nxt_fzero = (pc_ff >= top_addr);
                    nxt_pc    = pc_ff + `PC_STEP;
                end
                if (i_sp_load && !wake_vector) begin
                    nxt_sp = i_sp_value;
                end
            end
            default: begin
                nxt_state = S_STRAP;
            end
        endcase
    end

    // sequencer registers; every reset kind restarts at the reset vector
    always @(posedge i_clk) begin
        if (i_rst) begin
            state_ff   <= S_STRAP;
            size_ff    <= `SIZE_64K;
            cfg_cnt_ff <= 3'h0;
            pc_ff      <= `VEC_RESET;
            sp_ff      <= `SP_RESET;
            push_ff    <= 1'b0;
            tos_ff     <= `PC_RESET;
            faddr_ff   <= `PC_RESET;
            frd_ff     <= 1'b0;
            fkind_ff   <= 1'b0;
            ftag_ff    <= 2'h0;
            fzero_ff   <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            size_ff    <= nxt_size;
            cfg_cnt_ff <= nxt_cfg_cnt;
            pc_ff      <= nxt_pc;
            sp_ff      <= nxt_sp;
            push_ff    <= nxt_push;
            tos_ff     <= nxt_tos;
            faddr_ff   <= nxt_faddr;
            frd_ff     <= nxt_frd;
            fkind_ff   <= nxt_fkind;
            ftag_ff    <= nxt_ftag;
            fzero_ff   <= nxt_fzero;
        end
    end

    // second stage follows the flash latency of one cycle
    always @(posedge i_clk) begin
        if (i_rst) begin
            rd_d_ff   <= 1'b0;
            kind_d_ff <= 1'b0;
            tag_d_ff  <= 2'h0;
            zero_d_ff <= 1'b0;
            addr_d_ff <= `PC_RESET;
        end else begin
            rd_d_ff   <= frd_ff;
            kind_d_ff <= fkind_ff;
            tag_d_ff  <= ftag_ff;
            zero_d_ff <= fzero_ff;
            addr_d_ff <= faddr_ff;
        end
    end

    // instruction result register
    always @(posedge i_clk) begin
        if (i_rst) begin
            fvalid_ff <= 1'b0;
            finstr_ff <= `NOP_WORD;
            fpc_ff    <= `PC_RESET;
        end else begin
            fvalid_ff <= rd_d_ff & ~kind_d_ff;
            if (rd_d_ff && !kind_d_ff) begin
                finstr_ff <= word_in;
                fpc_ff    <= addr_d_ff;
            end
        end
    end

    // configuration copy; unprogrammed value until the flash word lands
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_cfg
            // each slot owns its register, so no word has two driving processes
            reg  [15:0]  word_ff;
            always @(posedge i_clk) begin
                if (i_rst) begin
                    word_ff <= `CFG_RESET;
                end else if (rd_d_ff && kind_d_ff && tag_d_ff == gi) begin
                    // low byte sits at the lower address of each word
                    word_ff <= i_flash_rdata;
                end
            end
            assign cfg_flat[16*gi+15:16*gi] = word_ff;
        end
    endgenerate

    // done flag rises together with entry into instruction fetch
    always @(posedge i_clk) begin
        if (i_rst) begin
            done_ff <= 1'b0;
        end else if (state_ff == S_CFG && nxt_state == S_RUN) begin
            done_ff <= 1'b1;
        end
    end

    // data memory on its own bus, so it never contends with a fetch
    always @(posedge i_clk) begin
        if (i_dmem_en && i_dmem_we) begin
            dram[i_dmem_addr] <= i_dmem_wdata;
        end
    end

    // data read register; a write cycle does no read and leaves the read byte unchanged
    always @(posedge i_clk) begin
        if (i_rst) begin
            drdata_ff <= 8'h00;
            dvalid_ff <= 1'b0;
        end else begin
            dvalid_ff <= i_dmem_en & ~i_dmem_we;
            if (i_dmem_en && !i_dmem_we) begin
                drdata_ff <= dram[i_dmem_addr];
            end
        end
    end

    // outputs
    assign o_flash_addr           = faddr_ff;
    assign o_flash_rd             = frd_ff;
    assign o_fetch_valid          = fvalid_ff;
    assign o_fetch_instr          = finstr_ff;
    assign o_fetch_pc             = fpc_ff;
    assign o_pc                   = pc_ff;
    assign o_return_stack_pointer = sp_ff;
    assign o_stack_push           = push_ff;
    assign o_stack_top_upper_byte = tos_ff[20:16];
    assign o_stack_top_high_byte  = tos_ff[15:8];
    assign o_stack_top_low_byte   = tos_ff[7:0];
    assign o_dmem_rdata           = drdata_ff;
    assign o_dmem_valid           = dvalid_ff;
    assign o_setup_word_one       = cfg_flat[15:0];
    assign o_setup_word_two       = cfg_flat[31:16];
    assign o_setup_word_three     = cfg_flat[47:32];
    assign o_setup_word_reserved  = cfg_flat[63:48];
    assign o_cfg_done             = done_ff;

endmodule // prog_mem_map

// ==== prog_mem_map_defines.vh ====
`ifndef PROG_MEM_MAP_DEFINES_VH
`define PROG_MEM_MAP_DEFINES_VH

// program counter and address space
`define PC_W             21
`define PC_RESET         21'h000000
`define PC_STEP          21'h000002

// hard vectors
`define VEC_RESET        21'h000000
`define VEC_HIGH         21'h000008
`define VEC_LOW          21'h000018

// on-chip memory size options and their top-of-memory boundaries
`define SIZE_64K         2'h0
`define SIZE_96K         2'h1
`define SIZE_128K        2'h2
`define TOP_64K          21'h010000
`define TOP_96K          21'h018000
`define TOP_128K         21'h020000

// configuration area: four words at the top of on-chip memory
`define CFG_AREA_BYTES   21'h000008
`define CFG_WORDS        3'h4
`define CFG_LAST_IDX     2'h3
`define CFG_RESET        16'hffff

// zero word returned above the implemented memory, decodes as no-op
`define NOP_WORD         16'h0000

// return stack pointer
`define SP_W             5
`define SP_RESET         5'h00
`define SP_MAX           5'h1f
`define SP_STEP          5'h01

`endif

// ==== prog_mem_map_properties.sv ====
`timescale 1ns/100ps
`include "prog_mem_map_defines.vh"
module prog_mem_map_properties (
    input wire        i_clk,                             // clock
    input wire        i_rst,                             // reset
    input wire [1:0]  i_size_sel,                        // size
    input wire [20:0] o_flash_addr,                      // flash addr
    input wire        o_flash_rd,                        // flash read
    input wire        i_fetch_req,                       // fetch
    input wire        o_fetch_valid,                     // word out
    input wire [15:0] o_fetch_instr,                     // word
    input wire [20:0] o_fetch_pc,                        // word addr
    input wire [20:0] o_pc,                              // pc
    input wire        i_pc_load,                         // pc write
    input wire        i_wake_irq,                        // wake
    input wire        i_wake_high,                       // priority
    input wire        i_low_priority_global_irq_enable,  // low en
    input wire        i_high_priority_global_irq_enable, // high en
    input wire [4:0]  o_return_stack_pointer,            // sp
    input wire        o_stack_push,                      // push
    input wire [4:0]  o_stack_top_upper_byte,            // tos
    input wire [7:0]  o_stack_top_high_byte,             // tos
    input wire [7:0]  o_stack_top_low_byte,              // tos
    input wire        o_cfg_done                         // loaded
);
    // wake outranks everything, so a fetch in the same cycle is dropped
    wire        wake_en = i_wake_irq && o_cfg_done &&
                (i_low_priority_global_irq_enable || i_high_priority_global_irq_enable);
    wire        take    = i_fetch_req && o_cfg_done && !wake_en && !i_pc_load;
    wire [20:0] top     = (i_size_sel == `SIZE_96K) ? `TOP_96K :
                          (i_size_sel == `SIZE_128K) ? `TOP_128K : `TOP_64K;
    reg  [2:0]  cfg_rd_ff;
    // count configuration reads so each address can be predicted
    always @(posedge i_clk) begin
        if (i_rst)
            cfg_rd_ff <= 3'h0;
        else if (o_flash_rd && !o_cfg_done)
            cfg_rd_ff <= cfg_rd_ff + 3'h1;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    AST_PC_HELD: assert property (!o_cfg_done |-> o_pc == `VEC_RESET)
        else $error("pc left reset vector before load");
    AST_CFG_DONE: assert property ($fell(i_rst) |-> ##[3:8] o_cfg_done)
        else $error("configuration load late");
    AST_CFG_ADDR: assert property (o_flash_rd && !o_cfg_done |->
        cfg_rd_ff < 3'h4 &&
        o_flash_addr == top - `CFG_AREA_BYTES + {17'h0, cfg_rd_ff, 1'b0})
        else $error("configuration read address wrong");
    AST_FETCH: assert property (take |=> o_flash_rd && o_flash_addr == $past(o_pc) ##2
        o_fetch_valid && o_fetch_pc == $past(o_pc, 3))
        else $error("fetch answer wrong");
    AST_PC_STEP: assert property (take |=> o_pc == $past(o_pc) + `PC_STEP)
        else $error("pc did not advance");
    AST_ZERO: assert property (o_fetch_valid && o_fetch_pc >= top |->
        o_fetch_instr == `NOP_WORD)
        else $error("read above memory not zero");
    AST_PUSH: assert property (wake_en |=> o_stack_push &&
        {o_stack_top_upper_byte, o_stack_top_high_byte, o_stack_top_low_byte} == $past(o_pc)
        && o_return_stack_pointer == (($past(o_return_stack_pointer) == `SP_MAX) ?
        `SP_MAX : $past(o_return_stack_pointer) + `SP_STEP))
        else $error("wake push wrong");
    AST_VECTOR: assert property (wake_en |=>
        o_pc == ($past(i_wake_high) ? `VEC_HIGH : `VEC_LOW))
        else $error("wake vector wrong");
    AST_NO_WAKE: assert property (i_wake_irq && o_cfg_done && !wake_en |=> !o_stack_push)
        else $error("push without enable");
endmodule // prog_mem_map_properties

bind prog_mem_map prog_mem_map_properties u_props (
    .i_clk(i_clk), .i_rst(i_rst), .i_size_sel(i_size_sel), .o_flash_addr(o_flash_addr),
    .o_flash_rd(o_flash_rd), .i_fetch_req(i_fetch_req), .o_fetch_valid(o_fetch_valid),
    .o_fetch_instr(o_fetch_instr), .o_fetch_pc(o_fetch_pc), .o_pc(o_pc),
    .i_pc_load(i_pc_load), .i_wake_irq(i_wake_irq), .i_wake_high(i_wake_high),
    .i_low_priority_global_irq_enable(i_low_priority_global_irq_enable),
    .i_high_priority_global_irq_enable(i_high_priority_global_irq_enable),
    .o_return_stack_pointer(o_return_stack_pointer), .o_stack_push(o_stack_push),
    .o_stack_top_upper_byte(o_stack_top_upper_byte),
    .o_stack_top_high_byte(o_stack_top_high_byte),
    .o_stack_top_low_byte(o_stack_top_low_byte), .o_cfg_done(o_cfg_done)
);

// ==== testbench.sv ====
`timescale 1ns/100ps
`include "prog_mem_map_defines.vh"
module testbench;
    logic        i_clk, i_rst, i_fetch_req, i_pc_load, i_wake_irq, i_wake_high, i_sp_load;
    logic        i_low_priority_global_irq_enable, i_high_priority_global_irq_enable;
    logic        i_dmem_en, i_dmem_we, o_flash_rd, o_fetch_valid, o_stack_push;
    logic        o_dmem_valid, o_cfg_done;
    logic [1:0]  i_size_sel;
    logic [3:0]  i_dmem_addr;
    logic [4:0]  i_sp_value, o_return_stack_pointer, o_stack_top_upper_byte;
    logic [7:0]  o_stack_top_high_byte, o_stack_top_low_byte, i_dmem_wdata, o_dmem_rdata;
    logic [15:0] i_flash_rdata, o_fetch_instr, o_setup_word_one, o_setup_word_two;
    logic [15:0] o_setup_word_three, o_setup_word_reserved;
    logic [20:0] o_flash_addr, o_fetch_pc, o_pc, i_pc_value, exp_pc;
    logic [36:0] fq[$];
    logic [36:0] pq[$];
    logic [36:0] dq[$];
    int          failures, num_checks;

    prog_mem_map #(.DATA_AW(4)) dut (.i_clk, .i_rst, .i_size_sel, .o_flash_addr, .o_flash_rd,
        .i_flash_rdata, .i_fetch_req, .o_fetch_valid, .o_fetch_instr, .o_fetch_pc, .o_pc,
        .i_pc_load, .i_pc_value, .i_wake_irq, .i_wake_high, .i_low_priority_global_irq_enable,
        .i_high_priority_global_irq_enable, .i_sp_load, .i_sp_value, .o_return_stack_pointer,
        .o_stack_push, .o_stack_top_upper_byte, .o_stack_top_high_byte, .o_stack_top_low_byte,
        .i_dmem_en, .i_dmem_we, .i_dmem_addr, .i_dmem_wdata, .o_dmem_rdata, .o_dmem_valid,
        .o_setup_word_one, .o_setup_word_two, .o_setup_word_three, .o_setup_word_reserved,
        .o_cfg_done);
    flash_model flash (.i_clk, .i_rd(o_flash_rd), .i_addr(o_flash_addr), .o_rdata(i_flash_rdata));

    // 125 MHz core clock
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    task step;
        @(posedge i_clk);
        #1;
    endtask

    task check(input logic [36:0] got, input logic [36:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    task results;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    function automatic logic [20:0] top_of(input logic [1:0] s);
        top_of = (s == `SIZE_96K) ? `TOP_96K : (s == `SIZE_128K) ? `TOP_128K : `TOP_64K;
    endfunction

    task do_reset(input logic [1:0] s);
        int n;
        i_size_sel = s;
        i_rst = 1'b1;
        repeat (20) step;
        i_rst = 1'b0;
        // a request held through the copy must stay unanswered until it lands
        i_fetch_req = 1'b1;
        for (n = 0; n < 20 && o_cfg_done !== 1'b1; n++) step;
        i_fetch_req = 1'b0;
        if (o_cfg_done !== 1'b1) begin
            failures++;
            results;
        end
        check(o_pc, `VEC_RESET, "pc after reset");
    endtask

    // expected words are noted as requests are made; the monitor pairs them
    task fetch(input logic [20:0] p, input int cnt, input bit ld);
        int k;
        if (ld) begin
            i_pc_load = 1'b1;
            i_pc_value = p;
            p[0] = 1'b0;
            step;
            i_pc_load = 1'b0;
        end
        i_fetch_req = 1'b1;
        for (k = 0; k < cnt; k++) begin
            fq.push_back({p, p >= top_of(i_size_sel) ? `NOP_WORD : flash.word_of(p)});
            p = p + `PC_STEP;
            step;
        end
        i_fetch_req = 1'b0;
        exp_pc = p;
        repeat (4) step;
    endtask

    task wake(input logic [1:0] en, input logic hi, input logic [4:0] sp0);
        i_sp_load = 1'b1;
        i_sp_value = sp0;
        step;
        i_sp_load = 1'b0;
        i_low_priority_global_irq_enable = en[0];
        i_high_priority_global_irq_enable = en[1];
        i_wake_high = hi;
        i_wake_irq = 1'b1;
        if (en != 2'h0) begin
            pq.push_back({(sp0 == `SP_MAX) ? `SP_MAX : sp0 + `SP_STEP, exp_pc});
            exp_pc = hi ? `VEC_HIGH : `VEC_LOW;
        end
        step;
        i_wake_irq = 1'b0;
        check(o_pc, exp_pc, "pc after wake");
        step;
    endtask

    task dmem(input logic [3:0] a, input logic [7:0] d);
        i_dmem_en = 1'b1;
        i_dmem_we = 1'b1;
        i_dmem_addr = a;
        i_dmem_wdata = d;
        step;
        i_dmem_we = 1'b0;
        dq.push_back(d);
        step;
        i_dmem_en = 1'b0;
    endtask

    // an answer with no note pending compares against unknown and fails
    always @(negedge i_clk) begin
        if (o_fetch_valid === 1'b1)
            check({o_fetch_pc, o_fetch_instr}, fq.size() ? fq.pop_front() : 'x, "fetch");
        if (o_stack_push === 1'b1)
            check({o_return_stack_pointer, o_stack_top_upper_byte, o_stack_top_high_byte,
                   o_stack_top_low_byte}, pq.size() ? pq.pop_front() : 'x, "push");
        if (o_dmem_valid === 1'b1)
            check(o_dmem_rdata, dq.size() ? dq.pop_front() : 'x, "data read");
    end

    initial begin
        logic [20:0] p;
        int          s, e;
        failures = 0;
        num_checks = 0;
        {i_rst, i_fetch_req, i_pc_load, i_wake_irq, i_wake_high, i_sp_load} = 6'h20;
        {i_low_priority_global_irq_enable, i_high_priority_global_irq_enable} = 2'h0;
        {i_dmem_en, i_dmem_we, i_dmem_addr, i_dmem_wdata, i_sp_value} = 19'h0;
        i_pc_value = 21'h0;
        i_size_sel = 2'h0;
        exp_pc = 21'h0;
        void'($urandom(63));
        for (s = 0; s < 4; s++) begin
            do_reset(s[1:0]);
            p = top_of(s[1:0]) - `CFG_AREA_BYTES;
            check(o_setup_word_one, flash.word_of(p), "word one");
            check(o_setup_word_two, flash.word_of(p + 21'h2), "word two");
            check(o_setup_word_three, flash.word_of(p + 21'h4), "word three");
            check(o_setup_word_reserved, flash.word_of(p + 21'h6), "word four");
            fetch(`VEC_RESET, 2, 1'b0);
            fetch(top_of(s[1:0]) - 21'h4, 4, 1'b1);
        end
        fetch(21'h1ffffc, 3, 1'b1);
        for (e = 0; e < 8; e++) begin
            wake(e[1:0], e[2], (e == 7) ? `SP_MAX : 5'($urandom % 31));
            fetch(exp_pc, 1, 1'b0);
        end
        repeat (4) begin
            p = 21'($urandom) | 21'h000001;
            fork
                fetch(p, 3, 1'b1);
                dmem(4'($urandom), 8'($urandom));
            join
        end
        check(fq.size() + pq.size() + dq.size(), 0, "answers missing");
        results;
    end
endmodule // testbench
